// ### rtl/oed_cfg.svh
// Constants for the operand size and effective-address decoder.
`ifndef OED_CFG_SVH
`define OED_CFG_SVH
// ****************************************
// Bit positions of the most significant bit per size.
// ****************************************
`define OED_BYTE_MSB 7
`define OED_WORD_MSB 15
`define OED_LONG_MSB 31
// ****************************************
// Status word: reset value and implemented bits.
// ****************************************
`define OED_SR_RESET 16'h2700
`define OED_SR_IMPL_MASK 16'hb79f
`define OED_CCR_IMPL_MASK 16'h009f
// ****************************************
// Effective-address field codes.
// ****************************************
`define OED_MODE_DREG 3'h0
`define OED_MODE_AREG 3'h1
`define OED_MODE_IND 3'h2
`define OED_MODE_POSTINC 3'h3
`define OED_MODE_PREDEC 3'h4
`define OED_MODE_DISP16 3'h5
`define OED_MODE_INDEX8 3'h6
`define OED_MODE_EXT 3'h7
`define OED_EXT_ABS_SHORT 3'h0
`define OED_EXT_ABS_LONG 3'h1
`define OED_EXT_PC_DISP 3'h2
`define OED_EXT_PC_INDEX 3'h3
`define OED_EXT_IMM 3'h4
// ****************************************
// Opcode masks and patterns of the omitted groups.
// ****************************************
`define OED_BCD_MASK 16'hb1f0
`define OED_BCD_PAT 16'h8100
`define OED_NBCD_MASK 16'hffc0
`define OED_NBCD_PAT 16'h4800
`define OED_BFLD_MASK 16'hf8c0
`define OED_BFLD_PAT 16'he8c0
`define OED_ROTM_MASK 16'hfcc0
`define OED_ROTM_PAT 16'he4c0
`define OED_ROTR_MASK 16'hf010
`define OED_ROTR_PAT 16'he010
`define OED_DBCC_MASK 16'hf0f8
`define OED_DBCC_PAT 16'h50c8
`define OED_MUL64_MASK 16'hffc0
`define OED_MUL64_PAT 16'h4c00
`define OED_MUL64_EXT_BIT 10
`endif

// ### rtl/oed_pkg.sv
// Types shared by the operand size and effective-address decoder.
package oed_pkg;
	// ****************************************
	// Operand sizes.
	// ****************************************
	typedef enum logic [1:0] {
		OED_SZ_BYTE = 2'b00,
		OED_SZ_WORD = 2'b01,
		OED_SZ_LONG = 2'b10,
		OED_SZ_BAD = 2'b11
	} oed_size_t;
	// ****************************************
	// Decoded addressing modes.
	// ****************************************
	typedef enum logic [3:0] {
		OED_EA_DREG = 4'b0000,
		OED_EA_AREG = 4'b0001,
		OED_EA_IND = 4'b0010,
		OED_EA_POSTINC = 4'b0011,
		OED_EA_PREDEC = 4'b0100,
		OED_EA_DISP16 = 4'b0101,
		OED_EA_INDEX8 = 4'b0110,
		OED_EA_PC_DISP = 4'b0111,
		OED_EA_PC_INDEX = 4'b1000,
		OED_EA_ABS_SHORT = 4'b1001,
		OED_EA_ABS_LONG = 4'b1010,
		OED_EA_IMM = 4'b1011,
		OED_EA_NONE = 4'b1111
	} oed_ea_mode_t;
	// Decoded mode with its categories.
	typedef struct packed {
		oed_ea_mode_t mode;
		logic [2:0] reg_num;
		logic is_data;
		logic is_memory;
		logic is_control;
		logic is_alterable;
	} oed_ea_info_t;
	// One operation handed to the decoder.
	typedef struct packed {
		logic valid;
		logic [15:0] opcode;
		logic [15:0] ext_word;
		oed_size_t size;
		logic src_is_addr;
		logic dst_is_addr;
		logic [31:0] src_value;
		logic [31:0] dst_old;
		logic [1:0] addr_lo;
	} oed_req_t;
	// Memory lane image of a store.
	typedef struct packed {
		logic [3:0] byte_en;
		logic [31:0] data;
	} oed_lane_t;
endpackage

// ### rtl/oed_decode.sv
// Operand organisation, status word access and effective-address decode.
`include "oed_cfg.svh"

module oed_decode (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire oed_pkg::oed_req_t req,
	input wire logic sr_wr_en,
	input wire logic sr_wr_ccr_only,
	input wire logic [15:0] sr_wdata,
	output logic rsp_valid_q,
	output oed_pkg::oed_ea_info_t ea_info_q,
	output logic illegal_q,
	output logic [31:0] result_q,
	output oed_pkg::oed_lane_t lane_q,
	output logic [15:0] sr_rdata_q,
	output logic [15:0] ccr_rdata_q
);
	// ****************************************
	// State and next values.
	// ****************************************
	logic [15:0] sr_q; // Stored status word, implemented bits only.
	logic [15:0] sr_d;
	logic rsp_valid_d;
	oed_pkg::oed_ea_info_t ea_info_d;
	logic illegal_d;
	logic [31:0] result_d;
	oed_pkg::oed_lane_t lane_d;
	logic [15:0] sr_rdata_d;
	logic [15:0] ccr_rdata_d;
	logic ea_bad; // Mode field combination outside the twelve modes.
	logic op_omitted; // Opcode from a group this core does not carry.
	logic size_bad; // Size code or register pairing not encodable.
	logic [31:0] src_sized; // Source sign-extended from bit 15 for words; byte and long sources pass unchanged.
	logic [15:0] lane_word; // Low word of the source for stores.

	// ****************************************
	// Effective-address decode.
	// ****************************************
	// Mode and register fields sit in the low six opcode bits.
	always_comb begin
		ea_info_d = '0;
		ea_info_d.reg_num = req.opcode[2:0];
		ea_bad = 1'b0;
		case (req.opcode[5:3])
			`OED_MODE_DREG: begin
				ea_info_d.mode = oed_pkg::OED_EA_DREG;
			end
			`OED_MODE_AREG: begin
				ea_info_d.mode = oed_pkg::OED_EA_AREG;
			end
			`OED_MODE_IND: begin
				ea_info_d.mode = oed_pkg::OED_EA_IND;
			end
			`OED_MODE_POSTINC: begin
				ea_info_d.mode = oed_pkg::OED_EA_POSTINC;
			end
			`OED_MODE_PREDEC: begin
				ea_info_d.mode = oed_pkg::OED_EA_PREDEC;
			end
			`OED_MODE_DISP16: begin
				ea_info_d.mode = oed_pkg::OED_EA_DISP16;
			end
			`OED_MODE_INDEX8: begin
				ea_info_d.mode = oed_pkg::OED_EA_INDEX8;
			end
			default: begin
				// Mode seven: the register field picks the mode.
				case (req.opcode[2:0])
					`OED_EXT_PC_DISP: begin
						ea_info_d.mode = oed_pkg::OED_EA_PC_DISP;
					end
					`OED_EXT_PC_INDEX: begin
						ea_info_d.mode = oed_pkg::OED_EA_PC_INDEX;
					end
					`OED_EXT_ABS_SHORT: begin
						ea_info_d.mode = oed_pkg::OED_EA_ABS_SHORT;
					end
					`OED_EXT_ABS_LONG: begin
						ea_info_d.mode = oed_pkg::OED_EA_ABS_LONG;
					end
					`OED_EXT_IMM: begin
						ea_info_d.mode = oed_pkg::OED_EA_IMM;
					end
					default: begin
						// Codes five to seven have no mode here.
						ea_info_d.mode = oed_pkg::OED_EA_NONE;
						ea_bad = 1'b1;
					end
				endcase
			end
		endcase
		// Categories follow from the mode alone.
		case (ea_info_d.mode)
			oed_pkg::OED_EA_DREG: begin
				ea_info_d.is_data = 1'b1;
				ea_info_d.is_alterable = 1'b1;
			end
			oed_pkg::OED_EA_AREG: begin
				ea_info_d.is_alterable = 1'b1;
			end
			oed_pkg::OED_EA_POSTINC, oed_pkg::OED_EA_PREDEC: begin
				ea_info_d.is_data = 1'b1;
				ea_info_d.is_memory = 1'b1;
				ea_info_d.is_alterable = 1'b1;
			end
			oed_pkg::OED_EA_IND, oed_pkg::OED_EA_DISP16, oed_pkg::OED_EA_INDEX8: begin
				ea_info_d.is_data = 1'b1;
				ea_info_d.is_memory = 1'b1;
				ea_info_d.is_control = 1'b1;
				ea_info_d.is_alterable = 1'b1;
			end
			oed_pkg::OED_EA_IMM: begin
				ea_info_d.is_data = 1'b1;
				ea_info_d.is_memory = 1'b1;
			end
			oed_pkg::OED_EA_NONE: begin
				ea_info_d.is_data = 1'b0;
			end
			default: begin
				// Program-counter and absolute modes are read-only.
				ea_info_d.is_data = 1'b1;
				ea_info_d.is_memory = 1'b1;
				ea_info_d.is_control = 1'b1;
			end
		endcase
	end

	// ****************************************
	// Omitted instruction groups.
	// ****************************************
	// Multiply-accumulate opcodes live on line ten and are never caught here.
	always_comb begin
		op_omitted = 1'b0;
		if ((req.opcode & `OED_BCD_MASK) == `OED_BCD_PAT) begin
			op_omitted = 1'b1;
		end
		if ((req.opcode & `OED_NBCD_MASK) == `OED_NBCD_PAT) begin
			op_omitted = 1'b1;
		end
		if ((req.opcode & `OED_BFLD_MASK) == `OED_BFLD_PAT) begin
			op_omitted = 1'b1;
		end
		if ((req.opcode & `OED_ROTM_MASK) == `OED_ROTM_PAT) begin
			op_omitted = 1'b1;
		end
		// Register rotates share the shift line; size code three is the memory form.
		if ((req.opcode & `OED_ROTR_MASK) == `OED_ROTR_PAT && req.opcode[7:6] != 2'b11) begin
			op_omitted = 1'b1;
		end
		if ((req.opcode & `OED_DBCC_MASK) == `OED_DBCC_PAT) begin
			op_omitted = 1'b1;
		end
		// The long multiply is legal only with a 32-bit product.
		if ((req.opcode & `OED_MUL64_MASK) == `OED_MUL64_PAT && req.ext_word[`OED_MUL64_EXT_BIT]) begin
			op_omitted = 1'b1;
		end
	end

	// ****************************************
	// Operand merge into the destination register.
	// ****************************************
	always_comb begin
		size_bad = (req.size == oed_pkg::OED_SZ_BAD);
		// An address register never pairs with a byte operand.
		if (req.size == oed_pkg::OED_SZ_BYTE && (req.src_is_addr || req.dst_is_addr)) begin
			size_bad = 1'b1;
		end
		src_sized = req.src_value;
		if (req.size == oed_pkg::OED_SZ_WORD) begin
			// Sign comes from bit fifteen, the word msb.
			src_sized = {{16{req.src_value[`OED_WORD_MSB]}}, req.src_value[`OED_WORD_MSB:0]};
		end
		if (req.dst_is_addr) begin
			result_d = src_sized;
		end else begin
			case (req.size)
				oed_pkg::OED_SZ_BYTE: begin
					result_d = {req.dst_old[31:`OED_BYTE_MSB + 1], req.src_value[`OED_BYTE_MSB:0]};
				end
				oed_pkg::OED_SZ_WORD: begin
					result_d = {req.dst_old[31:`OED_WORD_MSB + 1], req.src_value[`OED_WORD_MSB:0]};
				end
				oed_pkg::OED_SZ_LONG: begin
					result_d = req.src_value;
				end
				default: begin
					// Bad size leaves the register as it was.
					result_d = req.dst_old;
				end
			endcase
		end
		illegal_d = req.valid && (size_bad || ea_bad || op_omitted);
		rsp_valid_d = req.valid;
	end

	// ****************************************
	// Big-endian lane placement of a store.
	// ****************************************
	// Misaligned words and longwords get no byte enables; the bus side traps them.
	always_comb begin
		lane_word = req.src_value[15:0];
		lane_d = '0;
		case (req.size)
			oed_pkg::OED_SZ_BYTE: begin
				// Lower address means the more significant lane.
				lane_d.byte_en = 4'h8 >> req.addr_lo;
				lane_d.data = {4{req.src_value[7:0]}};
			end
			oed_pkg::OED_SZ_WORD: begin
				lane_d.data = {lane_word, lane_word};
				if (req.addr_lo == 2'h0) begin
					lane_d.byte_en = 4'hc;
				end else if (req.addr_lo == 2'h2) begin
					lane_d.byte_en = 4'h3;
				end
			end
			oed_pkg::OED_SZ_LONG: begin
				// High word rides the lanes of address N, low word N+2.
				lane_d.data = req.src_value;
				if (req.addr_lo == 2'h0) begin
					lane_d.byte_en = 4'hf;
				end
			end
			default: begin
				lane_d.byte_en = 4'h0;
			end
		endcase
	end

	// ****************************************
	// Status word and condition flags byte.
	// ****************************************
	// Both ports are 16 bits wide so every access is a whole word.
	always_comb begin
		sr_d = sr_q;
		if (sr_wr_en && sr_wr_ccr_only) begin
			// Upper byte of a flags write is dropped; the mask is applied at full width
			// so the system byte is kept rather than lost to a widened concatenation.
			sr_d = {sr_q[15:8], 8'h00} | (sr_wdata & `OED_CCR_IMPL_MASK);
		end else if (sr_wr_en) begin
			// Masking keeps reserved bits clear even if software sets them.
			sr_d = sr_wdata & `OED_SR_IMPL_MASK;
		end
		sr_rdata_d = sr_d & `OED_SR_IMPL_MASK;
		ccr_rdata_d = sr_d & `OED_CCR_IMPL_MASK;
	end

	// ****************************************
	// Registers.
	// ****************************************
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sr_q <= `OED_SR_RESET;
			rsp_valid_q <= 1'b0;
			ea_info_q <= '0;
			illegal_q <= 1'b0;
			result_q <= '0;
			lane_q <= '0;
			sr_rdata_q <= `OED_SR_RESET;
			ccr_rdata_q <= `OED_SR_RESET & `OED_CCR_IMPL_MASK;
		end else begin
			sr_q <= sr_d;
			rsp_valid_q <= rsp_valid_d;
			ea_info_q <= ea_info_d;
			illegal_q <= illegal_d;
			result_q <= result_d;
			lane_q <= lane_d;
			sr_rdata_q <= sr_rdata_d;
			ccr_rdata_q <= ccr_rdata_d;
		end
	end

	// ****************************************
	// Assertions.
	// ****************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	byte_keep_high_a: assert property (req.valid && !req.dst_is_addr && req.size == oed_pkg::OED_SZ_BYTE
		|=> result_q[31:8] == $past(req.dst_old[31:8]) && result_q[7:0] == $past(req.src_value[7:0]))
		else $error("byte op changed high bits");
	long_full_a: assert property (req.valid && req.size == oed_pkg::OED_SZ_LONG
		|=> result_q == $past(req.src_value))
		else $error("longword result not full source");
	addr_byte_illegal_a: assert property (req.valid && req.size == oed_pkg::OED_SZ_BYTE && req.dst_is_addr
		|=> illegal_q)
		else $error("byte address operand not flagged");
	word_sign_ext_a: assert property (req.valid && req.dst_is_addr && req.size == oed_pkg::OED_SZ_WORD
		|=> result_q[31:16] == {16{result_q[15]}} && result_q[15:0] == $past(req.src_value[15:0]))
		else $error("word source not sign-extended");
	reserved_zero_a: assert property ((sr_rdata_q & ~`OED_SR_IMPL_MASK) == 16'h0000)
		else $error("reserved status bit reads one");
	flags_upper_zero_a: assert property (ccr_rdata_q[15:8] == 8'h00 && ccr_rdata_q[7:0] == sr_rdata_q[7:0])
		else $error("flags byte upper half not zero");
	flags_write_sys_a: assert property (sr_wr_en && sr_wr_ccr_only
		|=> sr_rdata_q[15:8] == $past(sr_q[15:8]) && ccr_rdata_q[7:0] == ($past(sr_wdata[7:0]) & 8'h9f))
		else $error("flags write disturbed system byte");
	word_lane_order_a: assert property (req.size == oed_pkg::OED_SZ_WORD && req.addr_lo == 2'h0
		|=> lane_q.byte_en == 4'hc && lane_q.data[31:16] == $past(req.src_value[15:0]))
		else $error("word high byte not at lower address");
	long_lane_order_a: assert property (req.size == oed_pkg::OED_SZ_LONG && req.addr_lo == 2'h0
		|=> lane_q.byte_en == 4'hf && lane_q.data[31:16] == $past(req.src_value[31:16]))
		else $error("longword high word misplaced");
	ext_mode_illegal_a: assert property (req.valid && req.opcode[5:3] == 3'h7 && req.opcode[2:0] > 3'h4
		|=> illegal_q && ea_info_q.mode == oed_pkg::OED_EA_NONE)
		else $error("bad extended mode not flagged");
	read_only_modes_a: assert property (rsp_valid_q && ea_info_q.mode inside {oed_pkg::OED_EA_PC_DISP,
		oed_pkg::OED_EA_PC_INDEX, oed_pkg::OED_EA_ABS_SHORT, oed_pkg::OED_EA_ABS_LONG, oed_pkg::OED_EA_IMM}
		|-> !ea_info_q.is_alterable)
		else $error("read-only mode marked alterable");
	dbcc_illegal_a: assert property (req.valid && (req.opcode & 16'hf0f8) == 16'h50c8 |=> illegal_q)
		else $error("decrement-and-branch not flagged");
endmodule

// ### testbench/oed_decode_bench.sv
// Self-checking bench for the operand size and effective-address decoder.
module oed_decode_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Stimulus and observed signals.
	// ****************************************
	logic core_clk = 1'b0; // 50 MHz core clock.
	logic reset_n = 1'b0; // Held low for the first five cycles.
	oed_pkg::oed_req_t req = '0; // Operation handed to the decoder.
	logic sr_wr_en = 1'b0; // Status word write strobe.
	logic sr_wr_ccr_only = 1'b0; // Restricts a write to the flags byte.
	logic [15:0] sr_wdata = 16'h0000; // Status word write data.
	logic rsp_valid_q;
	oed_pkg::oed_ea_info_t ea_info_q;
	logic illegal_q;
	logic [31:0] result_q;
	oed_pkg::oed_lane_t lane_q;
	logic [15:0] sr_rdata_q;
	logic [15:0] ccr_rdata_q;
	int fail_count = 0; // Mismatches seen so far.
	int n_checks = 0; // Comparisons made so far.
	// Free-running clock, 20 ns period.
	always #10 core_clk = ~core_clk;
	oed_decode i_oed_decode (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.req(req),
		.sr_wr_en(sr_wr_en),
		.sr_wr_ccr_only(sr_wr_ccr_only),
		.sr_wdata(sr_wdata),
		.rsp_valid_q(rsp_valid_q),
		.ea_info_q(ea_info_q),
		.illegal_q(illegal_q),
		.result_q(result_q),
		.lane_q(lane_q),
		.sr_rdata_q(sr_rdata_q),
		.ccr_rdata_q(ccr_rdata_q)
	);
	// ****************************************
	// Shared helpers.
	// ****************************************
	// Compares with case inequality so an unknown never passes.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Presents one valid operation at the falling edge; returns once the answer has settled.
	task apply(input logic [15:0] op, input logic [15:0] ext, input oed_pkg::oed_size_t sz, input logic sa,
		input logic da, input logic [31:0] src, input logic [31:0] dold, input logic [1:0] alo);
		@(negedge core_clk);
		req = '{1'b1, op, ext, sz, sa, da, src, dold, alo};
		@(posedge core_clk);
		#1;
	endtask
	// Raises one status word write; the strobe stays up if the next call follows at once.
	task sr_put(input logic co, input logic [15:0] d);
		@(negedge core_clk);
		sr_wr_en = 1'b1;
		sr_wr_ccr_only = co;
		sr_wdata = d;
	endtask
	// Drops the strobe and waits two edges so either register stage has landed.
	task sr_idle;
		@(negedge core_clk);
		sr_wr_en = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	// ****************************************
	// Scenarios.
	// ****************************************
	// Data register destination: byte and word sizes change only the low byte or word.
	task test_data_sizes;
		apply(16'h0000, 16'h0000, oed_pkg::OED_SZ_BYTE, 1'b0, 1'b0, 32'h1234_a5c3, 32'hdead_beef, 2'h0);
		chk(result_q, 32'hdead_bec3);
		chk(32'(rsp_valid_q), 32'h1);
		apply(16'h0000, 16'h0000, oed_pkg::OED_SZ_WORD, 1'b0, 1'b0, 32'h1234_a5c3, 32'hdead_beef, 2'h0);
		chk(result_q, 32'hdead_a5c3);
		apply(16'h0000, 16'h0000, oed_pkg::OED_SZ_LONG, 1'b0, 1'b0, 32'h1234_a5c3, 32'hdead_beef, 2'h0);
		chk(result_q, 32'h1234_a5c3);
		// The byte sign bit must land at position 7 and the word sign bit at 15.
		apply(16'h0000, 16'h0000, oed_pkg::OED_SZ_BYTE, 1'b0, 1'b0, 32'hffff_ff80, 32'h0000_0000, 2'h0);
		chk(result_q, 32'h0000_0080);
		apply(16'h0000, 16'h0000, oed_pkg::OED_SZ_WORD, 1'b0, 1'b0, 32'hffff_8000, 32'h0000_0000, 2'h0);
		chk(result_q, 32'h0000_8000);
	endtask
	// Address register source and destination handling, including the refused byte size.
	task test_addr_regs;
		apply(16'h0008, 16'h0000, oed_pkg::OED_SZ_WORD, 1'b0, 1'b1, 32'h0000_8001, 32'h5555_5555, 2'h0);
		chk(result_q, 32'hffff_8001);
		apply(16'h0008, 16'h0000, oed_pkg::OED_SZ_WORD, 1'b0, 1'b1, 32'h1234_7fff, 32'h5555_5555, 2'h0);
		chk(result_q, 32'h0000_7fff);
		apply(16'h0008, 16'h0000, oed_pkg::OED_SZ_LONG, 1'b0, 1'b1, 32'h8765_4321, 32'h5555_5555, 2'h0);
		chk(result_q, 32'h8765_4321);
		apply(16'h0008, 16'h0000, oed_pkg::OED_SZ_WORD, 1'b1, 1'b0, 32'habcd_1234, 32'hffff_0000, 2'h0);
		chk(result_q, 32'hffff_1234);
		apply(16'h0008, 16'h0000, oed_pkg::OED_SZ_LONG, 1'b1, 1'b0, 32'habcd_1234, 32'hffff_0000, 2'h0);
		chk(result_q, 32'habcd_1234);
		apply(16'h0008, 16'h0000, oed_pkg::OED_SZ_BYTE, 1'b0, 1'b1, 32'h0000_0011, 32'h0, 2'h0);
		chk(32'(illegal_q), 32'h1);
		apply(16'h0008, 16'h0000, oed_pkg::OED_SZ_BYTE, 1'b1, 1'b0, 32'h0000_0011, 32'h0, 2'h0);
		chk(32'(illegal_q), 32'h1);
		apply(16'h0000, 16'h0000, oed_pkg::OED_SZ_BAD, 1'b0, 1'b0, 32'h0, 32'h0, 2'h0);
		chk(32'(illegal_q), 32'h1);
	endtask
	// Store lanes: the lowest address owns the most significant byte lane.
	task test_lanes;
		for (int a = 0; a < 4; a++) begin
			apply(16'h0010, 16'h0000, oed_pkg::OED_SZ_BYTE, 1'b0, 1'b0, 32'h0000_005a, 32'h0, 2'(a));
			chk(32'(lane_q.byte_en), 32'(4'h8 >> a));
			chk(lane_q.data, 32'h5a5a_5a5a);
		end
		apply(16'h0010, 16'h0000, oed_pkg::OED_SZ_WORD, 1'b0, 1'b0, 32'h0000_beef, 32'h0, 2'h0);
		chk(32'({lane_q.byte_en, lane_q.data[31:16]}), 32'h000c_beef);
		apply(16'h0010, 16'h0000, oed_pkg::OED_SZ_WORD, 1'b0, 1'b0, 32'h0000_beef, 32'h0, 2'h2);
		chk(32'({lane_q.byte_en, lane_q.data[15:0]}), 32'h0003_beef);
		apply(16'h0010, 16'h0000, oed_pkg::OED_SZ_WORD, 1'b0, 1'b0, 32'h0000_beef, 32'h0, 2'h1);
		chk(32'(lane_q.byte_en), 32'h0);
		apply(16'h0010, 16'h0000, oed_pkg::OED_SZ_LONG, 1'b0, 1'b0, 32'h0102_0304, 32'h0, 2'h0);
		chk(32'({4'h0, lane_q.byte_en}), 32'h0000_000f);
		chk(lane_q.data, 32'h0102_0304);
		apply(16'h0010, 16'h0000, oed_pkg::OED_SZ_LONG, 1'b0, 1'b0, 32'h0102_0304, 32'h0, 2'h2);
		chk(32'(lane_q.byte_en), 32'h0);
	endtask
	// Every mode and register field pair, with the expected categories worked out per mode.
	task test_ea_modes;
		logic [3:0] em;
		logic ed, emm, ec, ea, bad;
		for (int m = 0; m < 8; m++) begin
			for (int r = 0; r < 8; r++) begin
				apply({10'h000, 3'(m), 3'(r)}, 16'h0000, oed_pkg::OED_SZ_LONG, 1'b0, 1'b0, 32'h0, 32'h0, 2'h0);
				bad = 1'b0;
				if (m < 7) begin
					em = 4'(m);
					ed = (m != 1);
					emm = (m >= 2);
					ec = (m == 2 || m >= 5);
					ea = 1'b1;
				end else begin
					case (r)
						0: em = oed_pkg::OED_EA_ABS_SHORT;
						1: em = oed_pkg::OED_EA_ABS_LONG;
						2: em = oed_pkg::OED_EA_PC_DISP;
						3: em = oed_pkg::OED_EA_PC_INDEX;
						4: em = oed_pkg::OED_EA_IMM;
						default: em = oed_pkg::OED_EA_NONE;
					endcase
					ed = (r < 5);
					emm = (r < 5);
					ec = (r < 4);
					ea = 1'b0;
					bad = (r > 4);
				end
				chk(32'({ea_info_q.mode, ea_info_q.is_data, ea_info_q.is_memory, ea_info_q.is_control,
					ea_info_q.is_alterable}), 32'({em, ed, emm, ec, ea}));
				if (m < 7) chk(32'(ea_info_q.reg_num), 32'(r));
				chk(32'(illegal_q), 32'(bad));
			end
		end
	endtask
	// One opcode of each omitted group, then a multiply-accumulate opcode that must stay legal.
	task test_omitted;
		logic [15:0] ops [8];
		ops = '{16'h8100, 16'h4800, 16'he8c0, 16'he4c0, 16'he018, 16'h50c8, 16'h4c00, 16'ha000};
		for (int i = 0; i < 8; i++) begin
			apply(ops[i], (i == 6) ? 16'h0400 : 16'h0000, oed_pkg::OED_SZ_LONG, 1'b0, 1'b0, 32'h0, 32'h0, 2'h0);
			chk(32'(illegal_q), 32'(i != 7));
		end
		// The 32-bit product form of the multiply shares the opcode and must pass.
		apply(16'h4c00, 16'h0000, oed_pkg::OED_SZ_LONG, 1'b0, 1'b0, 32'h0, 32'h0, 2'h0);
		chk(32'(illegal_q), 32'h0);
		// An idle slot carrying an illegal pattern must not raise the flag.
		@(negedge core_clk);
		req.opcode = 16'h8100;
		req.valid = 1'b0;
		@(posedge core_clk);
		#1;
		chk(32'({rsp_valid_q, illegal_q}), 32'h0);
	endtask
	// Status word writes, whole and flags-only, back to back.
	task test_status_word;
		sr_put(1'b0, 16'hffff);
		sr_idle();
		chk(32'(sr_rdata_q), 32'h0000_b79f);
		chk(32'(ccr_rdata_q), 32'h0000_009f);
		// A non-zero system byte shows that a flags-only write leaves it alone.
		sr_put(1'b0, 16'h3100);
		sr_put(1'b1, 16'hff9c);
		sr_idle();
		chk(32'(sr_rdata_q), 32'h0000_319c);
		chk(32'(ccr_rdata_q), 32'h0000_009c);
	endtask
	// ****************************************
	// Verdict and run control.
	// ****************************************
	task finish_test;
		if (fail_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// The whole run is about a hundred cycles; ten thousand means a hang.
	initial begin
		#200000;
		fail_count++;
		finish_test();
	end
	initial begin
		repeat (5) @(posedge core_clk);
		#1;
		chk(32'(sr_rdata_q), 32'h0000_2700);
		chk(32'(ccr_rdata_q), 32'h0);
		@(negedge core_clk);
		reset_n = 1'b1;
		test_data_sizes();
		test_addr_regs();
		test_lanes();
		test_ea_modes();
		test_omitted();
		test_status_word();
		finish_test();
	end
endmodule
